// >>> pkg/rsm_defines.vh
// shared constants of the reference select and monitor block
`ifndef RSM_DEFINES_VH
`define RSM_DEFINES_VH

`define RSM_CLK_NS 5
// measurement gate, one per millisecond
`define RSM_GATE_US 1000
`define RSM_GATE_CYC (`RSM_GATE_US * 1000 / `RSM_CLK_NS)
// qualification time and minute length, in gates
`define RSM_QUAL_S 10
`define RSM_QUAL_GATES (`RSM_QUAL_S * 1000000 / `RSM_GATE_US)
`define RSM_MIN_S 60
`define RSM_MIN_GATES (`RSM_MIN_S * 1000000 / `RSM_GATE_US)
// parallel port ready handshake
`define RSM_RDY_MAX_NS 250
`define RSM_RDY_LOW_NS 100
`define RSM_RDY_LOW_CYC ((`RSM_RDY_LOW_NS + `RSM_CLK_NS - 1) / `RSM_CLK_NS)

// loop modes
`define RSM_MODE_FREE 2'h0
`define RSM_MODE_LOCK 2'h1
`define RSM_MODE_HOLD 2'h2
// active reference codes: 0 none, 1..8 references, 9 cross-couple
`define RSM_REF_NONE 4'h0
`define RSM_REF_LAST 4'h8
`define RSM_REF_XREF 4'h9

// frequency codes and nominal edge counts per gate
`define RSM_FRQ_NONE 4'h0
`define RSM_FRQ_LAST 4'h9
`define RSM_NOM_1 20'h00008
`define RSM_NOM_2 20'h00608
`define RSM_NOM_3 20'h00800
`define RSM_NOM_4 20'h032A0
`define RSM_NOM_5 20'h04BF0
`define RSM_NOM_6 20'h06540
`define RSM_NOM_7 20'h097E0
`define RSM_NOM_8 20'h0CA80
`define RSM_NOM_9 20'h12FC0
// pull-in range is in tenths of a ppm
`define RSM_PPM_SCALE 48'h000000989680

// operating choice word fields
`define RSM_OPW_REF_LSB 0
`define RSM_OPW_MODE_LSB 4
// control mode word: automatic selection bit, manual after reset
`define RSM_CTL_AUTO_BIT 1
`define RSM_CTL_RESET 8'h00
// loop state word fields
`define RSM_LSW_LOS_BIT 0
`define RSM_LSW_MODE_LSB 1
`define RSM_LSW_REF_LSB 3
`define RSM_LSW_CFG_BIT 7

`endif

// >>> rtl/rsm_qualify.v
// per-reference qualification timer
`timescale 1ns/10ps
module rsm_qualify #(
   parameter QUAL_GATES = 10000
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire gate_tick,
   input wire good,
   output wire qualified
);
   reg [31:0] cnt_q;

   // count good gates, saturate one past the limit, restart on a bad gate
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q <= 32'h0;
      end else if (gate_tick) begin
         if (!good) begin
            cnt_q <= 32'h0;
         end else if (cnt_q <= QUAL_GATES) begin
            cnt_q <= cnt_q + 32'h1;
         end
      end
   end

   assign qualified = (cnt_q > QUAL_GATES);
endmodule

// >>> rtl/rsm_autosel.v
// picks the highest-priority available reference
`timescale 1ns/10ps
module rsm_autosel #(
   parameter N = 8,
   parameter PW = 3
) (
   input wire [N-1:0] avail,
   input wire [N*PW-1:0] prio,
   output reg [2:0] best_idx,
   output reg best_valid,
   output reg [PW-1:0] best_prio
);
   integer i;

   // lower priority value wins, ties go to the lower index
   always @* begin
      best_idx = 3'h0;
      best_valid = 1'b0;
      best_prio = {PW{1'b1}};
      for (i = 0; i < N; i = i + 1) begin
         if (avail[i] &&
             (!best_valid || prio[i*PW +: PW] < best_prio)) begin
            best_idx = i[2:0];
            best_valid = 1'b1;
            best_prio = prio[i*PW +: PW];
         end
      end
   end
endmodule

// >>> rtl/rsm_top.v
// reference monitoring, qualification and mode selection top
`timescale 1ns/10ps
`include "rsm_defines.vh"

// Function
// - hardwired master decodes select pins: 0 free run, 1-8 locked, else hold over
// - slave mode always locks on the cross-couple input
// - oscillator input is TTL when type pin high, PECL when low
// - after reset, configuration data is loaded before normal operation
// - configuration comes from host bus on 0, EEPROM on 1
// - register port is 8-bit parallel on 1, SPI on 0
// - each reference reports signal presence in its own activity bit
// - cross-couple presence and frequency sit in four low bits
// - each reference frequency offset is measured and reported separately
// - per reference pull-in flag against range set in 0.1 ppm steps
// - qualified only after active and in range for over 10 s
// - available is qualified and unmasked; only available ones auto-select
// - manual mode raises signal-missing pin and status bit on loss
// - each reference frequency is auto-detected and readable
// - cross-couple frequency is detected from the same set
// - control bit 1 picks manual or automatic; manual selects by word
// - automatic mode picks by priority among available references
// - on failure switch to best remaining; each reference's own ref_revertive bit marks it revertive
// - revert to higher-priority reference only if current revertive, after delay
// - hardwired pin high: pins govern, matching words read-only
// - master when primary pin is 1, slave when 0
module rsm_top #(
   parameter GATE_CYC = `RSM_GATE_CYC,
   parameter QUAL_GATES = `RSM_QUAL_GATES,
   parameter MIN_GATES = `RSM_MIN_GATES,
   parameter OFFW = 16,
   parameter RNGW = 16
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire hardwired_control_pin,
   input wire master_select_pin,
   input wire [3:0] mode_ref_select_pins,
   input wire oscillator_input_type_pin,
   input wire config_source_pin,
   input wire port_type_pin,
   input wire eeprom_load_done,
   input wire host_cfg_done,
   input wire [7:0] reference_inputs,
   input wire xref_input,
   input wire ctl_mode_wr,
   input wire [7:0] ctl_mode_data,
   input wire op_word_wr,
   input wire [7:0] operating_choice_word,
   input wire [7:0] ref_mask,
   input wire [23:0] ref_priority,
   input wire [7:0] ref_revertive,
   input wire [RNGW-1:0] max_pullin_range,
   input wire [7:0] ref_rev_delay,
   input wire par_cs_n,
   input wire par_ale,
   output reg osc_ttl_q,
   output reg port_parallel_q,
   output reg cfg_from_eeprom_q,
   output reg cfg_ready_q,
   output reg par_rdy_q,
   output reg par_rdy_oe_q,
   output reg [7:0] ref_activity_q,
   output reg [3:0] xref_activity_q,
   output reg [31:0] ref_freq_q,
   output reg [8*OFFW-1:0] ref_offset_q,
   output reg [7:0] ref_pullin_q,
   output reg [7:0] ref_qualified_q,
   output reg [7:0] ref_available_q,
   output reg auto_mode_q,
   output reg [1:0] loop_mode_q,
   output reg [3:0] active_ref_q,
   output reg rev_pending_q,
   output reg signal_missing_flag_q,
   output reg [7:0] loop_state_word_q
);
   function [19:0] nom_count;
      input [3:0] code;
      begin
         case (code)
            4'h1: nom_count = `RSM_NOM_1;
            4'h2: nom_count = `RSM_NOM_2;
            4'h3: nom_count = `RSM_NOM_3;
            4'h4: nom_count = `RSM_NOM_4;
            4'h5: nom_count = `RSM_NOM_5;
            4'h6: nom_count = `RSM_NOM_6;
            4'h7: nom_count = `RSM_NOM_7;
            4'h8: nom_count = `RSM_NOM_8;
            4'h9: nom_count = `RSM_NOM_9;
            default: nom_count = 20'h0;
         endcase
      end
   endfunction

   // nearest supported frequency, split at midpoints of nominals
   function [3:0] freq_code;
      input [19:0] cnt;
      reg [20:0] mid;
      integer k;
      begin
         mid = 21'h0;
         freq_code = (cnt == 20'h0) ? `RSM_FRQ_NONE : 4'h1;
         for (k = 1; k < 9; k = k + 1) begin
            mid = ({1'b0, nom_count(k[3:0])} +
                   {1'b0, nom_count(k[3:0] + 4'h1)}) >> 1;
            if ({1'b0, cnt} > mid) begin
               freq_code = k[3:0] + 4'h1;
            end
         end
      end
   endfunction

   function pullin_ok;
      input [19:0] cnt;
      input [3:0] code;
      input [RNGW-1:0] rng;
      reg [19:0] nom;
      reg [19:0] diff;
      reg [47:0] lhs;
      reg [47:0] rhs;
      begin
         nom = nom_count(code);
         diff = (cnt > nom) ? cnt - nom : nom - cnt;
         lhs = {28'h0, diff} * `RSM_PPM_SCALE;
         rhs = {{(48-RNGW){1'b0}}, rng} * {28'h0, nom};
         pullin_ok = (code != `RSM_FRQ_NONE) && (lhs <= rhs);
      end
   endfunction

   // pin decode in hardwired master operation
   function [5:0] hw_decode;
      input [3:0] sel;
      begin
         if (sel == 4'h0) begin
            hw_decode = {`RSM_MODE_FREE, `RSM_REF_NONE};
         end else if (sel <= `RSM_REF_LAST) begin
            hw_decode = {`RSM_MODE_LOCK, sel};
         end else begin
            hw_decode = {`RSM_MODE_HOLD, `RSM_REF_NONE};
         end
      end
   endfunction

   reg [31:0] gate_cnt_q;
   reg [31:0] min_cnt_q;
   reg [8:0] prev_q;
   reg [19:0] edge_cnt_q [0:8];
   reg [7:0] ctl_word_q;
   reg [7:0] op_word_q;
   reg cfg_seen_q;
   reg ale_prev_q;
   reg [7:0] rdy_cnt_q;
   reg [7:0] pend_min_q;
   reg [2:0] pend_idx_q;
   reg [1:0] mode_d;
   reg [3:0] ref_d;
   reg pend_d;
   wire [31:0] code_all;
   wire [159:0] nom_all;
   wire gate_tick;
   wire min_tick;
   wire [8:0] in_all;
   wire [7:0] qual_w;
   wire [2:0] best_idx;
   wire best_valid;
   wire [2:0] best_prio;
   wire [2:0] cur_idx;
   wire cur_ok;
   wire outranks;
   wire los_d;
   integer i;
   localparam [7:0] RDY_LOW_CYC = `RSM_RDY_LOW_CYC;

   assign in_all = {xref_input, reference_inputs};
   assign gate_tick = (gate_cnt_q == GATE_CYC - 1);
   assign min_tick = gate_tick && (min_cnt_q == MIN_GATES - 1);

   // frequency code and nominal count of each reference
   genvar m;
   generate
      for (m = 0; m < 8; m = m + 1) begin : meas
         assign code_all[4*m +: 4] = freq_code(edge_cnt_q[m]);
         assign nom_all[20*m +: 20] = nom_count(code_all[4*m +: 4]);
      end
   endgenerate

   // edge counting per gate gives presence, frequency and offset
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         gate_cnt_q <= 32'h0;
         min_cnt_q <= 32'h0;
         prev_q <= 9'h0;
         for (i = 0; i < 9; i = i + 1) begin
            edge_cnt_q[i] <= 20'h0;
         end
         ref_activity_q <= 8'h0;
         xref_activity_q <= 4'h0;
         ref_freq_q <= 32'h0;
         ref_offset_q <= {8*OFFW{1'b0}};
         ref_pullin_q <= 8'h0;
      end else begin
         prev_q <= in_all;
         gate_cnt_q <= gate_tick ? 32'h0 : gate_cnt_q + 32'h1;
         if (gate_tick) begin
            min_cnt_q <= min_tick ? 32'h0 : min_cnt_q + 32'h1;
         end
         for (i = 0; i < 9; i = i + 1) begin
            if (gate_tick) begin
               edge_cnt_q[i] <= {19'h0, in_all[i] & ~prev_q[i]};
            end else if (in_all[i] & ~prev_q[i]) begin
               edge_cnt_q[i] <= edge_cnt_q[i] + 20'h1;
            end
         end
         if (gate_tick) begin
            for (i = 0; i < 8; i = i + 1) begin
               ref_activity_q[i] <= (edge_cnt_q[i] != 20'h0);
               ref_freq_q[4*i +: 4] <= code_all[4*i +: 4];
               ref_offset_q[OFFW*i +: OFFW] <=
                  edge_cnt_q[i][OFFW-1:0] -
                  nom_all[20*i +: OFFW];
               ref_pullin_q[i] <= pullin_ok(edge_cnt_q[i],
                                            code_all[4*i +: 4],
                                            max_pullin_range);
            end
            xref_activity_q <= freq_code(edge_cnt_q[8]);
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : qual
         rsm_qualify #(.QUAL_GATES(QUAL_GATES)) u_qual (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .gate_tick(gate_tick),
            .good(ref_activity_q[g] & ref_pullin_q[g]),
            .qualified(qual_w[g])
         );
      end
   endgenerate

   rsm_autosel #(.N(8), .PW(3)) u_sel (
      .avail(ref_available_q),
      .prio(ref_priority),
      .best_idx(best_idx),
      .best_valid(best_valid),
      .best_prio(best_prio)
   );

   // straps, configuration load and register words
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         osc_ttl_q <= 1'b0;
         port_parallel_q <= 1'b0;
         cfg_from_eeprom_q <= 1'b0;
         cfg_seen_q <= 1'b0;
         cfg_ready_q <= 1'b0;
         ctl_word_q <= `RSM_CTL_RESET;
         op_word_q <= 8'h0;
         ref_qualified_q <= 8'h0;
         ref_available_q <= 8'h0;
      end else begin
         osc_ttl_q <= oscillator_input_type_pin;
         port_parallel_q <= port_type_pin;
         if (!cfg_seen_q) begin
            cfg_seen_q <= 1'b1;
            cfg_from_eeprom_q <= config_source_pin;
         end else if (!cfg_ready_q) begin
            cfg_ready_q <= cfg_from_eeprom_q ? eeprom_load_done
                                             : host_cfg_done;
         end
         if (!hardwired_control_pin) begin
            if (ctl_mode_wr) begin
               ctl_word_q <= ctl_mode_data;
            end
            if (op_word_wr) begin
               op_word_q <= operating_choice_word;
            end
         end
         ref_qualified_q <= qual_w;
         ref_available_q <= qual_w & ref_mask;
      end
   end

   assign cur_idx = active_ref_q[2:0] - 3'h1;
   assign cur_ok = (loop_mode_q == `RSM_MODE_LOCK) &&
                   (active_ref_q != `RSM_REF_NONE) &&
                   (active_ref_q <= `RSM_REF_LAST) &&
                   ref_available_q[cur_idx];
   assign outranks = best_valid && (best_idx != cur_idx) &&
                     (best_prio < ref_priority[3*cur_idx +: 3]) &&
                     ref_revertive[cur_idx];

   // next mode and reference
   always @* begin
      mode_d = loop_mode_q;
      ref_d = active_ref_q;
      pend_d = 1'b0;
      if (!cfg_ready_q) begin
         mode_d = `RSM_MODE_FREE;
         ref_d = `RSM_REF_NONE;
      end else if (!master_select_pin) begin
         mode_d = `RSM_MODE_LOCK;
         ref_d = `RSM_REF_XREF;
      end else if (hardwired_control_pin) begin
         {mode_d, ref_d} = hw_decode(mode_ref_select_pins);
      end else if (!ctl_word_q[`RSM_CTL_AUTO_BIT]) begin
         mode_d = op_word_q[`RSM_OPW_MODE_LSB +: 2];
         ref_d = op_word_q[`RSM_OPW_REF_LSB +: 4];
         if (mode_d != `RSM_MODE_LOCK) begin
            ref_d = `RSM_REF_NONE;
         end else if (ref_d == `RSM_REF_NONE || ref_d > `RSM_REF_LAST) begin
            mode_d = `RSM_MODE_HOLD;
            ref_d = `RSM_REF_NONE;
         end
      end else if (!cur_ok) begin
         if (best_valid) begin
            mode_d = `RSM_MODE_LOCK;
            ref_d = {1'b0, best_idx} + 4'h1;
         end else begin
            mode_d = `RSM_MODE_HOLD;
            ref_d = `RSM_REF_NONE;
         end
      end else if (outranks) begin
         pend_d = 1'b1;
         if (rev_pending_q && pend_idx_q == best_idx &&
             pend_min_q >= ref_rev_delay) begin
            ref_d = {1'b0, best_idx} + 4'h1;
            pend_d = 1'b0;
         end
      end
   end

   // manual loss of the selected reference
   assign los_d = !(ctl_word_q[`RSM_CTL_AUTO_BIT] && !hardwired_control_pin)
                  && master_select_pin &&
                  (loop_mode_q == `RSM_MODE_LOCK) &&
                  (active_ref_q != `RSM_REF_NONE) &&
                  (active_ref_q <= `RSM_REF_LAST) &&
                  !ref_activity_q[cur_idx];

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         loop_mode_q <= `RSM_MODE_FREE;
         active_ref_q <= `RSM_REF_NONE;
         auto_mode_q <= 1'b0;
         rev_pending_q <= 1'b0;
         pend_idx_q <= 3'h0;
         pend_min_q <= 8'h0;
         signal_missing_flag_q <= 1'b0;
         loop_state_word_q <= 8'h0;
      end else begin
         loop_mode_q <= mode_d;
         active_ref_q <= ref_d;
         auto_mode_q <= ctl_word_q[`RSM_CTL_AUTO_BIT];
         rev_pending_q <= pend_d;
         if (!pend_d || !rev_pending_q || pend_idx_q != best_idx) begin
            pend_idx_q <= best_idx;
            pend_min_q <= 8'h0;
         end else if (min_tick && pend_min_q != 8'hFF) begin
            pend_min_q <= pend_min_q + 8'h1;
         end
         signal_missing_flag_q <= los_d;
         loop_state_word_q[`RSM_LSW_LOS_BIT] <= los_d;
         loop_state_word_q[`RSM_LSW_MODE_LSB +: 2] <= mode_d;
         loop_state_word_q[`RSM_LSW_REF_LSB +: 4] <= ref_d;
         loop_state_word_q[`RSM_LSW_CFG_BIT] <= cfg_ready_q;
      end
   end

   // parallel ready handshake
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ale_prev_q <= 1'b0;
         rdy_cnt_q <= 8'h0;
         par_rdy_q <= 1'b1;
         par_rdy_oe_q <= 1'b0;
      end else begin
         ale_prev_q <= par_ale;
         par_rdy_oe_q <= port_parallel_q && !par_cs_n;
         if (par_cs_n || !port_parallel_q) begin
            rdy_cnt_q <= 8'h0;
            par_rdy_q <= 1'b1;
         end else if (par_ale && !ale_prev_q) begin
            rdy_cnt_q <= RDY_LOW_CYC;
            par_rdy_q <= 1'b0;
         end else if (rdy_cnt_q != 8'h0) begin
            rdy_cnt_q <= rdy_cnt_q - 8'h1;
            par_rdy_q <= (rdy_cnt_q == 8'h1);
         end
      end
   end
endmodule

// >>> tb/rsm_properties.sv
// port assertions for the reference select and monitor block
`timescale 1ns/10ps
`include "rsm_defines.vh"
module rsm_properties #(
   parameter GATE_CYC = 50,
   parameter QUAL_GATES = 3
) (
   input logic ref_clk,
   input logic sys_rst,
   input logic hardwired_control_pin,
   input logic master_select_pin,
   input logic [3:0] mode_ref_select_pins,
   input logic oscillator_input_type_pin,
   input logic port_type_pin,
   input logic eeprom_load_done,
   input logic host_cfg_done,
   input logic [7:0] ref_mask,
   input logic par_cs_n,
   input logic par_ale,
   input logic osc_ttl_q,
   input logic port_parallel_q,
   input logic cfg_from_eeprom_q,
   input logic cfg_ready_q,
   input logic par_rdy_q,
   input logic [7:0] ref_activity_q,
   input logic [7:0] ref_pullin_q,
   input logic [7:0] ref_qualified_q,
   input logic [7:0] ref_available_q,
   input logic auto_mode_q,
   input logic [1:0] loop_mode_q,
   input logic [3:0] active_ref_q,
   input logic signal_missing_flag_q,
   input logic [7:0] loop_state_word_q
);
   wire [3:0] p = mode_ref_select_pins;
   wire [1:0] e_mode = p == 4'h0 ? `RSM_MODE_FREE :
      p <= 4'h8 ? `RSM_MODE_LOCK : `RSM_MODE_HOLD;
   wire [3:0] e_ref = p <= 4'h8 ? p : 4'h0;
   wire sel_done = cfg_from_eeprom_q ? eeprom_load_done : host_cfg_done;
   wire [3:0] ar = active_ref_q - 4'h1;
   wire los_c = master_select_pin && !(auto_mode_q && !hardwired_control_pin)
      && loop_mode_q == `RSM_MODE_LOCK && active_ref_q != 4'h0
      && active_ref_q <= 4'h8 && !ref_activity_q[ar[2:0]];
   logic [31:0] good_q, low_q;
   // cycles that reference one has been continuously good
   always @(posedge ref_clk) begin
      if (sys_rst || !(ref_activity_q[0] && ref_pullin_q[0]))
         good_q <= 32'h0;
      else
         good_q <= good_q + 32'h1;
   end
   // cycles that ready has been low
   always @(posedge ref_clk) begin
      if (par_rdy_q)
         low_q <= 32'h0;
      else
         low_q <= low_q + 32'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   hw_decode_a: assert property (
      (hardwired_control_pin && master_select_pin && cfg_ready_q
      && $stable(mode_ref_select_pins))[*4]
      |-> loop_mode_q == e_mode && active_ref_q == e_ref)
      else $error("hardwired decode wrong");
   slave_lock_a: assert property (
      (!master_select_pin && cfg_ready_q)[*4]
      |-> loop_mode_q == `RSM_MODE_LOCK && active_ref_q == `RSM_REF_XREF)
      else $error("slave not locked on cross-couple");
   osc_type_a: assert property (
      $stable(oscillator_input_type_pin)[*2]
      |-> osc_ttl_q == oscillator_input_type_pin)
      else $error("oscillator type mirror wrong");
   port_type_a: assert property (
      $stable(port_type_pin)[*2] |-> port_parallel_q == port_type_pin)
      else $error("port type mirror wrong");
   cfg_source_a: assert property (
      $rose(cfg_ready_q) |-> $past(sel_done) || $past(sel_done, 2))
      else $error("config ready without its source");
   rdy_low_a: assert property (
      $rose(par_ale) && !par_cs_n && port_parallel_q
      |-> ##[1:50] !par_rdy_q)
      else $error("ready not low within 250 ns");
   rdy_hold_a: assert property (
      $rose(par_rdy_q) && !par_cs_n && !$past(par_cs_n)
      |-> low_q >= 32'h14)
      else $error("ready low shorter than 100 ns");
   qual_time_a: assert property (
      $rose(ref_qualified_q[0]) |-> good_q > QUAL_GATES * GATE_CYC - 8)
      else $error("qualified too early");
   avail_and_a: assert property (
      $stable(ref_mask)[*3]
      |-> ref_available_q == (ref_qualified_q & ref_mask))
      else $error("available is not qualified and unmasked");
   los_flag_a: assert property (
      los_c[*3] |-> signal_missing_flag_q && loop_state_word_q[0])
      else $error("signal missing not raised");
   cover property ($rose(ref_qualified_q[0]));
   cover property ($rose(signal_missing_flag_q));
   cover property ($fell(par_rdy_q));
endmodule

bind rsm_top rsm_properties #(.GATE_CYC(GATE_CYC), .QUAL_GATES(QUAL_GATES))
   u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .hardwired_control_pin(hardwired_control_pin),
   .master_select_pin(master_select_pin),
   .mode_ref_select_pins(mode_ref_select_pins),
   .oscillator_input_type_pin(oscillator_input_type_pin),
   .port_type_pin(port_type_pin), .eeprom_load_done(eeprom_load_done),
   .host_cfg_done(host_cfg_done), .ref_mask(ref_mask),
   .par_cs_n(par_cs_n), .par_ale(par_ale), .osc_ttl_q(osc_ttl_q),
   .port_parallel_q(port_parallel_q), .cfg_from_eeprom_q(cfg_from_eeprom_q),
   .cfg_ready_q(cfg_ready_q), .par_rdy_q(par_rdy_q),
   .ref_activity_q(ref_activity_q), .ref_pullin_q(ref_pullin_q),
   .ref_qualified_q(ref_qualified_q), .ref_available_q(ref_available_q),
   .auto_mode_q(auto_mode_q), .loop_mode_q(loop_mode_q),
   .active_ref_q(active_ref_q), .signal_missing_flag_q(signal_missing_flag_q),
   .loop_state_word_q(loop_state_word_q));

// >>> tb/rsm_ref_model.sv
// reference clock sources feeding the block
`timescale 1ns/10ps
module rsm_ref_model #(
   parameter PER = 50
) (
   input logic ref_clk,
   input logic [8:0] src_en,
   output logic [7:0] reference_inputs,
   output logic xref_input
);
   int ph = 0;
   // eight rising edges in every gate, the 8 kHz count
   wire lvl = ph % 6 < 3 && ph < 48;
   always @(posedge ref_clk)
      ph <= ph == PER - 1 ? 0 : ph + 1;
   // a silent source is held low
   assign reference_inputs = src_en[7:0] & {8{lvl}};
   assign xref_input = src_en[8] & lvl;
endmodule

// >>> tb/testbench.sv
// self-checking bench for the reference select and monitor block
`timescale 1ns/10ps
module testbench;
   logic ref_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic hw = 1'h0, ms = 1'h1, ost = 1'h1, csrc = 1'h0, ptype = 1'h1;
   logic ee = 1'h0, hd = 1'h0, cw = 1'h0, ow = 1'h0, cs_n = 1'h1, ale = 1'h0;
   logic [3:0] sel = 4'h0;
   logic [7:0] cd = 8'h00, od = 8'h00, mask = 8'hFF, rev = 8'h00, dly = 8'h03;
   logic [23:0] pri = 24'hFFFE39;
   logic [15:0] rng = 16'h0064;
   logic [8:0] en = 9'h000;
   wire [7:0] refs, act, pin, qual, avl, lsw;
   wire [3:0] xact, aref;
   wire [31:0] freq;
   wire [127:0] offs;
   wire [1:0] mode;
   wire xr, ttl, par, eep, rdy_cfg, rdy, oe, am, pend, signal_missing_flag;
   int errors = 0, compares = 0, i;
   always #2.5 ref_clk = ~ref_clk;
   rsm_ref_model #(.PER(50)) PM (.ref_clk(ref_clk), .src_en(en),
      .reference_inputs(refs), .xref_input(xr));
   rsm_top #(.GATE_CYC(50), .QUAL_GATES(3), .MIN_GATES(2)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .hardwired_control_pin(hw),
      .master_select_pin(ms), .mode_ref_select_pins(sel),
      .oscillator_input_type_pin(ost), .config_source_pin(csrc),
      .port_type_pin(ptype), .eeprom_load_done(ee), .host_cfg_done(hd),
      .reference_inputs(refs), .xref_input(xr), .ctl_mode_wr(cw),
      .ctl_mode_data(cd), .op_word_wr(ow), .operating_choice_word(od),
      .ref_mask(mask), .ref_priority(pri), .ref_revertive(rev),
      .max_pullin_range(rng), .ref_rev_delay(dly), .par_cs_n(cs_n),
      .par_ale(ale), .osc_ttl_q(ttl), .port_parallel_q(par),
      .cfg_from_eeprom_q(eep), .cfg_ready_q(rdy_cfg), .par_rdy_q(rdy),
      .par_rdy_oe_q(oe), .ref_activity_q(act), .xref_activity_q(xact),
      .ref_freq_q(freq), .ref_offset_q(offs), .ref_pullin_q(pin),
      .ref_qualified_q(qual), .ref_available_q(avl), .auto_mode_q(am),
      .loop_mode_q(mode), .active_ref_q(aref), .rev_pending_q(pend),
      .signal_missing_flag_q(signal_missing_flag), .loop_state_word_q(lsw));
   task stop_test;
      if (errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", n, e, g);
         errors++;
      end
   endtask
   task tmo(input int k, input int lim);
      if (k >= lim) begin
         $display("[FAIL] wait exp done got timeout");
         errors++;
         stop_test;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task wr_ctl(input logic [7:0] d);
      cd = d;
      cw = 1'h1;
      cyc(1);
      cw = 1'h0;
      cyc(2);
   endtask
   task wr_op(input logic [1:0] m, input logic [3:0] r);
      od = {2'h0, m, r};
      ow = 1'h1;
      cyc(1);
      ow = 1'h0;
      cyc(2);
   endtask
   initial begin
      cyc(2);
      sys_rst = 1'h0;
      hd = 1'h1;
      for (i = 0; i < 10 && rdy_cfg !== 1'h1; i++) cyc(1);
      tmo(i, 10);
      chk("cfg_eeprom", 0, eep);
      for (i = 0; i < 2; i++) begin
         ost = i[0];
         ptype = i[0];
         cyc(3);
         chk("osc_ttl", i, ttl);
         chk("port_par", i, par);
      end
      sys_rst = 1'h1;
      csrc = 1'h1;
      cyc(2);
      sys_rst = 1'h0;
      cyc(8);
      chk("cfg_ready", 0, rdy_cfg);
      ee = 1'h1;
      cyc(4);
      chk("cfg_ready", 1, rdy_cfg);
      chk("cfg_eeprom", 1, eep);
      hw = 1'h1;
      for (i = 0; i < 16; i++) begin
         sel = i[3:0];
         cyc(4);
         chk("hw_mode", i == 0 ? 0 : i <= 8 ? 1 : 2, mode);
         chk("hw_ref", i >= 1 && i <= 8 ? i : 0, aref);
      end
      wr_op(2'h1, 4'h2);
      chk("hw_ro", 2, mode);
      ms = 1'h0;
      cyc(4);
      chk("slave_mode", 1, mode);
      chk("slave_ref", 9, aref);
      ms = 1'h1;
      hw = 1'h0;
      mask = 8'h05;
      en = 9'h107;
      cyc(120);
      chk("qual_early", 0, qual);
      for (i = 0; i < 600 && qual !== 8'h07; i++) cyc(1);
      tmo(i, 600);
      chk("activity", 8'h07, act);
      chk("xref_act", 1, xact);
      chk("freq", 32'h111, freq);
      chk("offset", 0, offs[31:0]);
      chk("pullin", 8'h07, pin);
      chk("avail", 8'h05, avl);
      wr_op(2'h1, 4'h9);
      chk("man_bad", 2, mode);
      wr_op(2'h1, 4'h2);
      chk("man_mode", 1, mode);
      chk("man_ref", 2, aref);
      en = 9'h105;
      for (i = 0; i < 200 && signal_missing_flag !== 1'h1; i++) cyc(1);
      tmo(i, 200);
      chk("los_pin", 1, signal_missing_flag);
      cyc(2);
      chk("lsw_los", 1, lsw[0]);
      wr_ctl(8'h02);
      cyc(2);
      chk("auto_ref", 3, aref);
      chk("auto_mode", 1, am);
      chk("lsw_auto", 8'h9A, lsw);
      rev = 8'h01;
      en = 9'h101;
      for (i = 0; i < 200 && aref !== 4'h1; i++) cyc(1);
      tmo(i, 200);
      en = 9'h105;
      for (i = 0; i < 600 && pend !== 1'h1; i++) cyc(1);
      tmo(i, 600);
      chk("rev_hold", 1, aref);
      en = 9'h101;
      for (i = 0; i < 200 && pend !== 1'h0; i++) cyc(1);
      tmo(i, 200);
      chk("rev_drop", 1, aref);
      en = 9'h105;
      for (i = 0; i < 600 && pend !== 1'h1; i++) cyc(1);
      tmo(i, 600);
      for (i = 0; i < 400 && aref !== 4'h3; i++) cyc(1);
      tmo(i, 400);
      cs_n = 1'h0;
      cyc(2);
      chk("rdy_oe", 1, oe);
      ale = 1'h1;
      cyc(1);
      ale = 1'h0;
      cyc(1);
      chk("rdy_low", 0, rdy);
      cyc(18);
      chk("rdy_hold", 0, rdy);
      cyc(1);
      chk("rdy_high", 1, rdy);
      ptype = 1'h0;
      cyc(61); // host keeps 305 ns between accesses
      ale = 1'h1;
      cyc(1);
      ale = 1'h0;
      cyc(2);
      chk("rdy_spi", 1, rdy);
      chk("rdy_oe_spi", 0, oe);
      cs_n = 1'h1;
      stop_test;
   end
endmodule
